// ---- testbench/fec_capture_monitor.sv ----
// Port checks for the capture unit
`timescale 1ns/10ps
module fec_capture_monitor #(
  parameter PINS = 4,
  parameter TAG_BITS = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hold_read,
  input wire logic hold_valid,
  input wire logic [TAG_BITS-1:0] hold_tag,
  input wire logic [PINS-1:0] hold_pins,
  input wire logic [TAG_BITS-1:0] timer_value,
  input wire logic queue_nonempty
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_timer; $changed(timer_value) |=> $stable(timer_value)[*7] ##1
    timer_value == $past(timer_value) + 1'b1; endproperty
  a_timer: assert property (p_timer) else $error("timer step wrong");
  property p_space; $rose(hold_valid) |-> !queue_nonempty[*8]; endproperty
  a_space: assert property (p_space) else $error("entries too close");
  property p_pins; hold_valid |-> hold_pins != 0; endproperty
  a_pins: assert property (p_pins) else $error("empty pin mask");
  property p_tag; $rose(hold_valid) |-> timer_value - hold_tag <= 16'h1; endproperty
  a_tag: assert property (p_tag) else $error("tag not from timer");
  property p_stand; hold_valid && !hold_read |=> hold_valid && $stable(hold_tag); endproperty
  a_stand: assert property (p_stand) else $error("holding changed");
  property p_refill; hold_read && queue_nonempty |=> hold_valid; endproperty
  a_refill: assert property (p_refill) else $error("no refill");
  property p_order; hold_read && hold_valid && queue_nonempty |=> hold_tag > $past(hold_tag);
  endproperty
  a_order: assert property (p_order) else $error("tag order wrong");
  property p_empty; !hold_valid |-> !queue_nonempty; endproperty
  a_empty: assert property (p_empty) else $error("queue behind empty hold");
  c_queue: cover property ($rose(queue_nonempty));
  c_refill: cover property (hold_read && queue_nonempty);
  c_first: cover property ($rose(hold_valid));
endmodule
bind fec_capture fec_capture_monitor #(.PINS(PINS), .TAG_BITS(TAG_BITS)) u_mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .hold_read(hold_read), .hold_valid(hold_valid),
  .hold_tag(hold_tag), .hold_pins(hold_pins), .timer_value(timer_value),
  .queue_nonempty(queue_nonempty));

// ---- testbench/fec_pin_source.sv ----
// Behavioural model of the external event pins
`timescale 1ns/10ps
module fec_pin_source (
  input wire logic clk_sys,
  input wire logic [3:0] flip,
  output logic [3:0] event_pin
);
  // One toggle is one transition, so it counts as an event in both-edges mode
  initial event_pin = 4'h0;
  always @(posedge clk_sys) event_pin <= event_pin ^ flip;
endmodule

// ---- testbench/tb_event_time_tag_fifo.sv ----
// Directed bench for the capture unit
`timescale 1ns/10ps
module tb_event_time_tag_fifo;
  logic clk_sys = 0, rst_n = 0, mode_load = 0, hold_read = 0, overflow_clear = 0;
  logic [7:0] mode_data = 8'hAA;
  logic [3:0] flip = 4'h0, event_pin, hold_pins;
  logic [15:0] hold_tag, timer_value, t0, t1, skips;
  logic hold_valid, overflow, queue_nonempty;
  int num_errors = 0, n_compared = 0;
  fec_pin_source src (.clk_sys(clk_sys), .flip(flip), .event_pin(event_pin));
  fec_capture dut (.clk_sys(clk_sys), .rst_n(rst_n), .event_pin(event_pin),
    .mode_load(mode_load), .mode_data(mode_data), .hold_read(hold_read),
    .overflow_clear(overflow_clear), .hold_valid(hold_valid), .hold_tag(hold_tag),
    .hold_pins(hold_pins), .timer_value(timer_value), .overflow(overflow),
    .queue_nonempty(queue_nonempty));
  initial forever #5 clk_sys = ~clk_sys;
  task chk(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Spacing of 12 lets any toggle reach a sample tick and land
  task pulse(logic [3:0] m);
    @(posedge clk_sys) flip <= m;
    @(posedge clk_sys) flip <= 4'h0;
  endtask
  task rd;
    @(posedge clk_sys) hold_read <= 1'b1;
    @(posedge clk_sys) hold_read <= 1'b0;
    #1;
  endtask
  task t_timer;
    step(1);
    t0 = timer_value;
    step(72);
    chk("timer", t0 + 16'h9, timer_value);
    $display("timer test done");
  endtask
  task t_order;
    pulse(4'h1);
    step(12);
    chk("first pins", 4'h1, hold_pins);
    chk("queue after first", 1'b0, queue_nonempty);
    t0 = hold_tag;
    pulse(4'h6);
    step(12);
    chk("queue after second", 1'b1, queue_nonempty);
    rd;
    chk("merged pins", 4'h6, hold_pins);
    chk("tag advanced", 1'b1, hold_tag > t0);
    rd;
    chk("hold empty", 1'b0, hold_valid);
    $display("order test done");
  endtask
  // Holding plus eight queued entries, the tenth is dropped
  task t_fill;
    repeat (10) begin
      pulse(4'h8);
      step(9);
    end
    step(12);
    chk("overflow", 1'b1, overflow);
    t0 = 16'h0;
    repeat (10) begin
      t0 = t0 + hold_valid;
      rd;
    end
    chk("entries kept", 16'h9, t0);
    chk("drained", 1'b0, hold_valid);
    @(posedge clk_sys) overflow_clear <= 1'b1;
    @(posedge clk_sys) overflow_clear <= 1'b0;
    #1;
    chk("overflow cleared", 1'b0, overflow);
    $display("fill test done");
  endtask
  // Pin 0 rising, pin 1 falling, pin 2 both edges, pin 3 off
  task t_mode;
    @(posedge clk_sys) mode_load <= 1'b1;
    mode_data <= 8'hE4;
    @(posedge clk_sys) mode_load <= 1'b0;
    pulse(4'hF);
    step(12);
    chk("falling modes", 4'h6, hold_pins);
    pulse(4'hF);
    step(12);
    rd;
    chk("rising modes", 4'h5, hold_pins);
    rd;
    // Both toggles fall between two ticks, so the pin looks unchanged
    step(2);
    pulse(4'h4);
    pulse(4'h4);
    step(12);
    chk("lost pulse", 1'b0, hold_valid);
    $display("mode test done");
  endtask
  // Eight gaps of nine clocks span nine timer counts, so one gap skips a tag
  task t_skip;
    repeat (9) begin
      pulse(4'h4);
      step(7);
    end
    chk("queue full without loss", 1'b0, overflow);
    t0 = hold_tag;
    skips = 16'h0;
    repeat (8) begin
      t1 = hold_tag;
      rd;
      chk("tag gap", 1'b1, hold_tag - t1 == 16'h1 || hold_tag - t1 == 16'h2);
      skips = skips + (hold_tag - t1 == 16'h2);
    end
    chk("tag span", 16'h9, hold_tag - t0);
    chk("skipped tags", 16'h1, skips);
    rd;
    chk("skip drained", 1'b0, hold_valid);
    $display("skip test done");
  endtask
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    mode_load <= 1'b1;
    @(posedge clk_sys) mode_load <= 1'b0;
    t_timer;
    t_order;
    t_fill;
    t_mode;
    t_skip;
    complete_run;
  end
endmodule

// ---- verilog/fec_capture.v ----
// Fast event capture unit: pin sampling, time tags, queue and holding stage
`timescale 1ns/10ps
`include "fec_event_map.vh"

module fec_capture #(
  parameter PINS = `FEC_PINS,
  parameter TAG_BITS = `FEC_TAG_BITS,
  parameter DEPTH = `FEC_QUEUE_DEPTH,
  parameter AW = `FEC_QUEUE_ADDR
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [PINS-1:0] event_pin,
  input wire mode_load,
  input wire [PINS*`FEC_MODE_BITS-1:0] mode_data,
  input wire hold_read,
  input wire overflow_clear,
  output reg hold_valid,
  output reg [TAG_BITS-1:0] hold_tag,
  output reg [PINS-1:0] hold_pins,
  output reg [TAG_BITS-1:0] timer_value,
  output reg overflow,
  output wire queue_nonempty
);

  localparam WIDTH = PINS + TAG_BITS;

  reg [3:0] timer_pre;
  reg [3:0] sample_cnt;
  reg [PINS-1:0] pin_last;
  reg [PINS*`FEC_MODE_BITS-1:0] mode_cfg;
  wire sample_tick;
  wire [PINS-1:0] pin_hit;
  wire entry_valid;
  wire [WIDTH-1:0] entry_data;
  wire q_in_valid;
  wire q_in_ready;
  wire q_out_valid;
  wire q_out_ready;
  wire [WIDTH-1:0] q_out_data;
  wire hold_free;
  wire direct_load;
  reg next_hold_valid;
  reg [WIDTH-1:0] next_hold_data;

  // Mode has no reset on purpose; its value is unknown until loaded
  always @(posedge clk_sys) begin
    if (mode_load) begin
      mode_cfg <= mode_data;
    end
  end

  // Free-running tag timer, one count per eight clocks
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_pre <= `FEC_PRE_ZERO;
      timer_value <= {TAG_BITS{1'b0}};
    end else if (timer_pre == `FEC_TIMER_PRE_LAST) begin
      timer_pre <= `FEC_PRE_ZERO;
      timer_value <= timer_value + 1'b1;
    end else begin
      timer_pre <= timer_pre + 1'b1;
    end
  end

  // Sampler runs on a nine-clock cycle; the mismatch causes tag skips
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt <= `FEC_PRE_ZERO;
    end else if (sample_cnt == `FEC_SAMPLE_LAST) begin
      sample_cnt <= `FEC_PRE_ZERO;
    end else begin
      sample_cnt <= sample_cnt + 1'b1;
    end
  end

  assign sample_tick = (sample_cnt == `FEC_SAMPLE_LAST);

  // Pins are compared only at sample ticks; pulses in between are lost
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_last <= {PINS{1'b0}};
    end else if (sample_tick) begin
      pin_last <= event_pin;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      wire [`FEC_MODE_BITS-1:0] pm;
      wire rise;
      wire fall;
      reg hit;
      assign pm = mode_cfg[i*`FEC_MODE_BITS +: `FEC_MODE_BITS];
      assign rise = event_pin[i] & ~pin_last[i];
      assign fall = ~event_pin[i] & pin_last[i];
      always @* begin
        case (pm)
          `FEC_MODE_RISE: hit = rise;
          `FEC_MODE_FALL: hit = fall;
          `FEC_MODE_BOTH: hit = rise | fall;
          `FEC_MODE_OFF: hit = 1'b0;
          default: hit = 1'b0;
        endcase
      end
      assign pin_hit[i] = hit & sample_tick;
    end
  endgenerate

  // All pins hit in one sample share one entry and one tag
  assign entry_valid = |pin_hit;
  // Tag is the timer at the sample; separate samples are nine clocks apart
  assign entry_data = {pin_hit, timer_value};

  assign hold_free = (hold_valid == `FEC_HOLD_EMPTY) | hold_read;
  assign direct_load = hold_free & ~q_out_valid & entry_valid;
  assign q_in_valid = entry_valid & ~direct_load;
  assign q_out_ready = hold_free;

  fec_queue #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_queue (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(entry_data),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_out_data)
  );

  assign queue_nonempty = q_out_valid;

  // Holding stage refill priority: queue head first, then a fresh entry
  always @* begin
    next_hold_valid = hold_valid;
    next_hold_data = {hold_pins, hold_tag};
    if (hold_free) begin
      if (q_out_valid) begin
        next_hold_valid = `FEC_HOLD_FULL;
        next_hold_data = q_out_data;
      end else if (direct_load) begin
        next_hold_valid = `FEC_HOLD_FULL;
        next_hold_data = entry_data;
      end else begin
        next_hold_valid = `FEC_HOLD_EMPTY;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_valid <= `FEC_HOLD_EMPTY;
      hold_tag <= {TAG_BITS{1'b0}};
      hold_pins <= {PINS{1'b0}};
    end else begin
      hold_valid <= next_hold_valid;
      hold_pins <= next_hold_data[WIDTH-1:TAG_BITS];
      hold_tag <= next_hold_data[TAG_BITS-1:0];
    end
  end

  // Full queue drops the entry; a new loss wins over a clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else if (q_in_valid & ~q_in_ready) begin
      overflow <= 1'b1;
    end else if (overflow_clear) begin
      overflow <= 1'b0;
    end
  end

endmodule

// ---- verilog/fec_event_map.vh ----
// Constants for the fast event capture unit
`ifndef FEC_EVENT_MAP_VH
`define FEC_EVENT_MAP_VH

// Clocks per timer count and per input sample
`define FEC_TIMER_STATES 4'h8
`define FEC_SAMPLE_STATES 4'h9
`define FEC_TIMER_PRE_LAST 4'h7
`define FEC_SAMPLE_LAST 4'h8
`define FEC_PRE_ZERO 4'h0

// Per-pin detection modes, two bits each
`define FEC_MODE_RISE 2'h0
`define FEC_MODE_FALL 2'h1
`define FEC_MODE_BOTH 2'h2
`define FEC_MODE_OFF 2'h3
`define FEC_MODE_BITS 2

// Defaults for the structure
`define FEC_PINS 4
`define FEC_TAG_BITS 16
`define FEC_QUEUE_DEPTH 8
`define FEC_QUEUE_ADDR 3

// Holding stage state codes
`define FEC_HOLD_EMPTY 1'h0
`define FEC_HOLD_FULL 1'h1

`endif

// ---- verilog/fec_queue.v ----
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
`include "fec_event_map.vh"

module fec_queue #(
  parameter WIDTH = 20,
  parameter DEPTH = `FEC_QUEUE_DEPTH,
  parameter AW = `FEC_QUEUE_ADDR
) (
  input wire clk_sys,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  wire [AW:0] depth_c;

  assign depth_c = DEPTH[AW:0];
  assign in_ready = (count != depth_c);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      // Pointers wrap at DEPTH, not only at a power of two
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
